//--- hw/srq_pkg.sv
// Constants and types for the status reporting and service request block
// What this block does
// - Failed sensor zeroing sets calibration bits one-four
// - Calibration condition, event and enable bits zero, five-fourteen, fifteen read zero
// - Enabled status byte bits raise service request
// - Summary bits gather lower registers and queues
// - Operation complete via standard event summary
// - Bit seven summarises operation; bit four measuring
// - Negative filter latches falling condition changes
// - Parallel poll bit ORs enable AND status
// - Serial poll returns status byte directly
// - Register reads return one bit-pattern number
// - Errors queue up; empty queue returns zero
// - Power-on clears queues; flag clears the rest
// - Clear-status clears events, byte, error queue
// - Preset clears operation and calibration enables, filters positive only
// - Device clear empties output, keeps settings
// - Command into unread output logs minus 410
// - Event register holds change until read
// - Thirty-entry queue; overflow writes minus 350
package srq_pkg;
   localparam int REG_W = 16;
   localparam int ERR_DEPTH = 30;
   localparam int ERR_W = 16;
   localparam logic [15:0] CAL_MASK = 16'h001E;
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2;
   localparam logic [15:0] ERR_QUERY_INT = 16'hFE66;
   localparam logic [15:0] PTR_RESET = 16'h7FFF;
   localparam int STB_ERRQ = 2;
   localparam int STB_QUES = 3;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_RQS = 6;
   localparam int STB_OPER = 7;
   localparam int OPER_MEAS = 4;
   localparam logic [7:0] SRE_USED = 8'hBC;
   typedef enum logic [3:0] {
      SRQ_SEL_STB, SRQ_SEL_SRE, SRQ_SEL_ESR, SRQ_SEL_ESE, SRQ_SEL_PPE,
      SRQ_SEL_OCOND, SRQ_SEL_OEVT, SRQ_SEL_OENA, SRQ_SEL_OPTR,
      SRQ_SEL_ONTR, SRQ_SEL_CCOND, SRQ_SEL_CEVT, SRQ_SEL_CENA,
      SRQ_SEL_CPTR, SRQ_SEL_CNTR, SRQ_SEL_ERR
   } srq_sel_e;
endpackage

//--- hw/srq_status.sv
// Status byte, event registers, error queue and poll answers
`timescale 1ns/1ps
`default_nettype none
module srq_status #(
   parameter int DEPTH = srq_pkg::ERR_DEPTH
) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic PON_CLEAR,
   input wire logic PON_PULSE,
   input wire logic [3:0] ZERO_FAIL,
   input wire logic MEASURING,
   input wire logic OPC_EVENT,
   input wire logic [7:0] ESR_EVENTS,
   input wire logic ERR_PUSH,
   input wire logic [srq_pkg::ERR_W-1:0] ERR_CODE,
   input wire logic MAV,
   input wire logic CMD_NEW,
   input wire logic CMD_CLS,
   input wire logic CMD_DCL,
   input wire logic CMD_PRESET,
   input wire logic WR_EN,
   input wire logic [3:0] WR_SEL,
   input wire logic [15:0] WR_DATA,
   input wire logic RD_EN,
   input wire logic [3:0] RD_SEL,
   input wire logic PP_INVERT,
   output logic [15:0] RD_DATA,
   output logic [7:0] STB,
   output logic SRQ,
   output logic PP_BIT,
   output logic CLEAR_OUTQ,
   output logic PARSER_STOP
);
   import srq_pkg::*;
   logic [15:0] ccond_r, cevt_r, cena_r, cptr_r, cntr_r;
   logic [15:0] ocond_r, oevt_r, oena_r, optr_r, ontr_r;
   logic [7:0] esr_r, ese_r, sre_r, ppe_r;
   logic [15:0] ccond_nxt, ocond_nxt, c_hit, o_hit;
   logic [ERR_W-1:0] errq_r [DEPTH];
   logic [4:0] rd_ptr_r, wr_ptr_r;
   logic [5:0] cnt_r;
   logic [3:0] zf_s1_r, zf_s2_r;
   logic meas_s1_r, meas_s2_r;
   logic rd_c, rd_o, rd_esr, rd_err, q_clear, q_pop, q_push, q_full;
   logic [ERR_W-1:0] push_code;
   logic stat_reset, rqs, esb, ques_sum, oper_sum;
   // Zeroing and measuring pins pass two flops before use
   always_ff @(posedge MCLK or negedge RESETN)
      if (!RESETN)
      begin
         zf_s1_r <= '0;
         zf_s2_r <= '0;
         meas_s1_r <= 1'b0;
         meas_s2_r <= 1'b0;
      end
      else
      begin
         zf_s1_r <= ZERO_FAIL;
         zf_s2_r <= zf_s1_r;
         meas_s1_r <= MEASURING;
         meas_s2_r <= meas_s1_r;
      end
   assign ccond_nxt = {11'h000, zf_s2_r, 1'b0} & CAL_MASK;
   assign ocond_nxt = 16'(meas_s2_r) << OPER_MEAS;
   // Filters qualify rising and falling changes
   assign c_hit = (ccond_nxt & ~ccond_r & cptr_r)
                | (~ccond_nxt & ccond_r & cntr_r);
   assign o_hit = (ocond_nxt & ~ocond_r & optr_r)
                | (~ocond_nxt & ocond_r & ontr_r);
   assign rd_c = RD_EN && RD_SEL == 4'(SRQ_SEL_CEVT);
   assign rd_o = RD_EN && RD_SEL == 4'(SRQ_SEL_OEVT);
   assign rd_esr = RD_EN && RD_SEL == 4'(SRQ_SEL_ESR);
   assign rd_err = RD_EN && RD_SEL == 4'(SRQ_SEL_ERR);
   assign stat_reset = PON_PULSE && PON_CLEAR;
   always_ff @(posedge MCLK or negedge RESETN)
      if (!RESETN)
      begin
         ccond_r <= '0;
         ocond_r <= '0;
      end
      else
      begin
         ccond_r <= ccond_nxt;
         ocond_r <= ocond_nxt;
      end
   // Event set wins over read clear, so nothing is lost
   always_ff @(posedge MCLK or negedge RESETN)
      if (!RESETN)
      begin
         cevt_r <= '0;
         oevt_r <= '0;
         esr_r <= '0;
      end
      else if (stat_reset || CMD_CLS)
      begin
         // Events landing in the clearing cycle survive
         cevt_r <= c_hit & CAL_MASK;
         oevt_r <= o_hit;
         esr_r <= ESR_EVENTS | 8'(OPC_EVENT);
      end
      else
      begin
         cevt_r <= (rd_c ? '0 : cevt_r) | (c_hit & CAL_MASK);
         oevt_r <= (rd_o ? '0 : oevt_r) | o_hit;
         esr_r <= (rd_esr ? '0 : esr_r) | ESR_EVENTS | 8'(OPC_EVENT);
      end
   // Enables and filters; preset leaves ESE/SRE/PPE alone
   always_ff @(posedge MCLK or negedge RESETN)
      if (!RESETN)
      begin
         cena_r <= '0;
         oena_r <= '0;
         cptr_r <= PTR_RESET;
         optr_r <= PTR_RESET;
         cntr_r <= '0;
         ontr_r <= '0;
         ese_r <= '0;
         sre_r <= '0;
         ppe_r <= '0;
      end
      else if (stat_reset)
      begin
         cena_r <= '0;
         oena_r <= '0;
         cptr_r <= PTR_RESET;
         optr_r <= PTR_RESET;
         cntr_r <= '0;
         ontr_r <= '0;
         ese_r <= '0;
         sre_r <= '0;
         ppe_r <= '0;
      end
      else if (CMD_PRESET)
      begin
         cena_r <= '0;
         oena_r <= '0;
         cptr_r <= PTR_RESET;
         optr_r <= PTR_RESET;
         cntr_r <= '0;
         ontr_r <= '0;
      end
      else if (WR_EN)
      begin
         case (WR_SEL)
            4'(SRQ_SEL_SRE): sre_r <= WR_DATA[7:0] & SRE_USED;
            4'(SRQ_SEL_ESE): ese_r <= WR_DATA[7:0];
            4'(SRQ_SEL_PPE): ppe_r <= WR_DATA[7:0];
            4'(SRQ_SEL_OENA): oena_r <= WR_DATA;
            4'(SRQ_SEL_OPTR): optr_r <= WR_DATA;
            4'(SRQ_SEL_ONTR): ontr_r <= WR_DATA;
            4'(SRQ_SEL_CENA): cena_r <= WR_DATA & CAL_MASK;
            4'(SRQ_SEL_CPTR): cptr_r <= WR_DATA;
            4'(SRQ_SEL_CNTR): cntr_r <= WR_DATA;
            default: ;
         endcase
      end
   // Error queue; overflow rewrites the newest slot
   assign q_clear = PON_PULSE || CMD_CLS;
   assign q_full = cnt_r == 6'(DEPTH);
   assign q_push = ERR_PUSH || (CMD_NEW && MAV);
   assign push_code = (CMD_NEW && MAV) ? ERR_QUERY_INT : ERR_CODE;
   assign q_pop = rd_err && cnt_r != '0;
   always_ff @(posedge MCLK or negedge RESETN)
      if (!RESETN)
      begin
         rd_ptr_r <= '0;
         wr_ptr_r <= '0;
         cnt_r <= '0;
      end
      else if (q_clear)
      begin
         // A push in the clearing cycle becomes the first entry
         rd_ptr_r <= '0;
         wr_ptr_r <= q_push ? 5'd1 : 5'd0;
         cnt_r <= q_push ? 6'd1 : 6'd0;
      end
      else
      begin
         if (q_pop)
            rd_ptr_r <= (rd_ptr_r == 5'(DEPTH - 1)) ? '0 : rd_ptr_r + 5'd1;
         if (q_push && (!q_full || q_pop))
            wr_ptr_r <= (wr_ptr_r == 5'(DEPTH - 1)) ? '0 : wr_ptr_r + 5'd1;
         if (q_push && !q_full && !q_pop)
            cnt_r <= cnt_r + 6'd1;
         else if (q_pop && !(q_push))
            cnt_r <= cnt_r - 6'd1;
      end
   always_ff @(posedge MCLK)
      if (q_push)
      begin
         if (q_clear)
            errq_r[0] <= push_code;
         else if (q_full && !q_pop)
            errq_r[(wr_ptr_r == '0) ? 5'(DEPTH - 1) : wr_ptr_r - 5'd1]
               <= ERR_OVERFLOW;
         else
            errq_r[wr_ptr_r] <= push_code;
      end
   // Summaries into the status byte
   assign ques_sum = |(cevt_r & cena_r);
   assign oper_sum = |(oevt_r & oena_r);
   assign esb = |(esr_r & ese_r);
   always_comb
   begin
      STB = '0;
      STB[STB_ERRQ] = cnt_r != '0;
      STB[STB_QUES] = ques_sum;
      STB[STB_MAV] = MAV;
      STB[STB_ESB] = esb;
      STB[STB_OPER] = oper_sum;
      rqs = |(STB & sre_r);
      STB[STB_RQS] = rqs;
   end
   assign SRQ = rqs;
   assign PP_BIT = (|(ppe_r & STB)) ^ PP_INVERT;
   assign CLEAR_OUTQ = PON_PULSE || CMD_DCL;
   assign PARSER_STOP = PON_PULSE || CMD_DCL;
   // Registered read data, one word per register
   always_ff @(posedge MCLK or negedge RESETN)
      if (!RESETN)
         RD_DATA <= '0;
      else if (RD_EN)
      begin
         case (RD_SEL)
            4'(SRQ_SEL_STB): RD_DATA <= {8'h00, STB};
            4'(SRQ_SEL_SRE): RD_DATA <= {8'h00, sre_r};
            4'(SRQ_SEL_ESR): RD_DATA <= {8'h00, esr_r};
            4'(SRQ_SEL_ESE): RD_DATA <= {8'h00, ese_r};
            4'(SRQ_SEL_PPE): RD_DATA <= {8'h00, ppe_r};
            4'(SRQ_SEL_OCOND): RD_DATA <= ocond_r;
            4'(SRQ_SEL_OEVT): RD_DATA <= oevt_r;
            4'(SRQ_SEL_OENA): RD_DATA <= oena_r;
            4'(SRQ_SEL_OPTR): RD_DATA <= optr_r;
            4'(SRQ_SEL_ONTR): RD_DATA <= ontr_r;
            4'(SRQ_SEL_CCOND): RD_DATA <= ccond_r & CAL_MASK;
            4'(SRQ_SEL_CEVT): RD_DATA <= cevt_r & CAL_MASK;
            4'(SRQ_SEL_CENA): RD_DATA <= cena_r;
            4'(SRQ_SEL_CPTR): RD_DATA <= cptr_r;
            4'(SRQ_SEL_CNTR): RD_DATA <= cntr_r;
            4'(SRQ_SEL_ERR): RD_DATA <= (cnt_r == '0) ? ERR_NONE
                                        : errq_r[rd_ptr_r];
            default: RD_DATA <= '0;
         endcase
      end
endmodule // srq_status
`default_nettype wire

//--- test/srq_status_assertions.sv
// Port checks for the status block
`timescale 1ns/1ps
`default_nettype none
module srq_status_chk
   import srq_pkg::*;
#(
   parameter int DEPTH = ERR_DEPTH
) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic PON_PULSE,
   input wire logic [3:0] ZERO_FAIL,
   input wire logic MEASURING,
   input wire logic MAV,
   input wire logic CMD_DCL,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire logic [3:0] RD_SEL,
   input wire logic PP_INVERT,
   input wire logic [15:0] RD_DATA,
   input wire logic [7:0] STB,
   input wire logic SRQ,
   input wire logic PP_BIT,
   input wire logic CLEAR_OUTQ
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   property p_outq; CLEAR_OUTQ == (PON_PULSE | CMD_DCL); endproperty
   a_outq: assert property (p_outq) else $error("outq");
   property p_mav; STB[4] == MAV; endproperty
   a_mav: assert property (p_mav) else $error("mav");
   property p_rqs; STB[6] == SRQ; endproperty
   a_rqs: assert property (p_rqs) else $error("rqs");
   property p_hold; !$past(RD_EN) |-> $stable(RD_DATA); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_cal; RD_EN && RD_SEL inside {SRQ_SEL_CCOND, SRQ_SEL_CEVT,
      SRQ_SEL_CENA} |=> (RD_DATA & ~CAL_MASK) == 16'h0000; endproperty
   a_cal: assert property (p_cal) else $error("cal");
   // Seven quiet edges cover the two-flop sync
   property p_zero; $stable(ZERO_FAIL)[*7] ##0 (RD_EN &&
      RD_SEL == SRQ_SEL_CCOND) |=> RD_DATA[4:1] == $past(ZERO_FAIL);
   endproperty
   a_zero: assert property (p_zero) else $error("zero");
   property p_meas; $stable(MEASURING)[*7] ##0 (RD_EN &&
      RD_SEL == SRQ_SEL_OCOND) |=> RD_DATA[4] == $past(MEASURING);
   endproperty
   a_meas: assert property (p_meas) else $error("meas");
   property p_pp; $changed(PP_INVERT) && $stable(STB) && !$past(WR_EN)
      && !$past(PON_PULSE) |-> PP_BIT != $past(PP_BIT); endproperty
   a_pp: assert property (p_pp) else $error("pp");
   c_srq: cover property ($rose(SRQ));
   c_cev: cover property (RD_EN && RD_SEL == SRQ_SEL_CEVT);
   c_pp: cover property ($fell(PP_BIT));
endmodule // srq_status_chk
bind srq_status srq_status_chk #(.DEPTH(DEPTH)) u_chk (
   .MCLK(MCLK),
   .RESETN(RESETN),
   .PON_PULSE(PON_PULSE),
   .ZERO_FAIL(ZERO_FAIL),
   .MEASURING(MEASURING),
   .MAV(MAV),
   .CMD_DCL(CMD_DCL),
   .WR_EN(WR_EN),
   .RD_EN(RD_EN),
   .RD_SEL(RD_SEL),
   .PP_INVERT(PP_INVERT),
   .RD_DATA(RD_DATA),
   .STB(STB),
   .SRQ(SRQ),
   .PP_BIT(PP_BIT),
   .CLEAR_OUTQ(CLEAR_OUTQ)
);
`default_nettype wire

//--- test/srq_ctrl_model.sv
// Bus controller model: programs, reads and polls the block
`timescale 1ns/1ps
`default_nettype none
module srq_ctrl_model
   import srq_pkg::*;
(
   input wire logic clk,
   input wire logic [15:0] rd_data,
   input wire logic pp_line,
   output logic wr_en,
   output logic [3:0] wr_sel,
   output logic [15:0] wr_data,
   output logic rd_en,
   output logic [3:0] rd_sel,
   output logic pp_inv
);
   initial {wr_en, wr_sel, wr_data, rd_en, rd_sel, pp_inv} = '0;
   // Idle select and data show the inverse, never a stale copy
   task automatic wr(input logic [3:0] s, input logic [15:0] v);
      @(posedge clk);
      #1 {wr_en, wr_sel, wr_data} = {1'b1, s, v};
      @(posedge clk);
      #1 {wr_en, wr_sel, wr_data} = {1'b0, ~s, ~v};
   endtask
   task automatic rd(input logic [3:0] s, output logic [15:0] v);
      @(posedge clk);
      #1 {rd_en, rd_sel} = {1'b1, s};
      @(posedge clk);
      #1 {rd_en, rd_sel} = {1'b0, ~s};
      v = rd_data;
   endtask
   task automatic setup_all();
      wr(SRQ_SEL_SRE, 16'h00FF);
      wr(SRQ_SEL_ESE, 16'h00FF);
      wr(SRQ_SEL_PPE, 16'h00FF);
   endtask
   task automatic poll(input logic inv, output logic b);
      @(posedge clk);
      #1 pp_inv = inv;
      @(posedge clk);
      #1 b = pp_line;
   endtask
endmodule // srq_ctrl_model
`default_nettype wire

//--- test/status_reporting_srq_tb_top.sv
// Self-checking bench for the status block
`timescale 1ns/1ps
`default_nettype none
module status_reporting_srq_tb_top;
   import srq_pkg::*;
   logic MCLK, RESETN, PON_CLEAR, MEASURING, MAV, b;
   logic [3:0] ZERO_FAIL;
   logic [15:0] ERR_CODE, d;
   logic [6:0] pl;
   wire OPC_EVENT = pl[0];
   wire ERR_PUSH = pl[1];
   wire CMD_NEW = pl[2];
   wire CMD_CLS = pl[3];
   wire CMD_PRESET = pl[4];
   wire PON_PULSE = pl[5];
   wire CMD_DCL = pl[6];
   logic [7:0] ESR_EVENTS;
   wire WR_EN, RD_EN, PP_INVERT, SRQ, PP_BIT, CLEAR_OUTQ, PARSER_STOP;
   wire [3:0] WR_SEL, RD_SEL;
   wire [15:0] WR_DATA, RD_DATA;
   wire [7:0] STB;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   srq_status #(.DEPTH(ERR_DEPTH)) dut (
      .MCLK(MCLK),
      .RESETN(RESETN),
      .PON_CLEAR(PON_CLEAR),
      .PON_PULSE(PON_PULSE),
      .ZERO_FAIL(ZERO_FAIL),
      .MEASURING(MEASURING),
      .OPC_EVENT(OPC_EVENT),
      .ESR_EVENTS(ESR_EVENTS),
      .ERR_PUSH(ERR_PUSH),
      .ERR_CODE(ERR_CODE),
      .MAV(MAV),
      .CMD_NEW(CMD_NEW),
      .CMD_CLS(CMD_CLS),
      .CMD_DCL(CMD_DCL),
      .CMD_PRESET(CMD_PRESET),
      .WR_EN(WR_EN),
      .WR_SEL(WR_SEL),
      .WR_DATA(WR_DATA),
      .RD_EN(RD_EN),
      .RD_SEL(RD_SEL),
      .PP_INVERT(PP_INVERT),
      .RD_DATA(RD_DATA),
      .STB(STB),
      .SRQ(SRQ),
      .PP_BIT(PP_BIT),
      .CLEAR_OUTQ(CLEAR_OUTQ),
      .PARSER_STOP(PARSER_STOP)
   );
   srq_ctrl_model ctl (.clk(MCLK), .rd_data(RD_DATA), .pp_line(PP_BIT),
      .wr_en(WR_EN), .wr_sel(WR_SEL), .wr_data(WR_DATA), .rd_en(RD_EN),
      .rd_sel(RD_SEL), .pp_inv(PP_INVERT));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pulse(input int n);
      @(posedge MCLK);
      #1 pl[n] = 1'b1;
      @(posedge MCLK);
      #1 pl[n] = 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_cal();
      ZERO_FAIL = 4'b1010;
      wt(6);
      ctl.rd(SRQ_SEL_CCOND, d);
      chk(d, 16'h0014);
      ctl.rd(SRQ_SEL_CEVT, d);
      chk(d, 16'h0014);
      ctl.rd(SRQ_SEL_CEVT, d);
      chk(d, 16'h0000);
   endtask
   task automatic t_srq();
      ctl.setup_all();
      pulse(0);
      wt(1);
      chk({8'h00, STB}, 16'h0060);
      ctl.rd(SRQ_SEL_STB, d);
      chk(d, 16'h0060);
      ctl.poll(1'b0, b);
      chk({15'h0, b}, 16'h0001);
      ctl.poll(1'b1, b);
      chk({15'h0, b}, 16'h0000);
      ctl.poll(1'b0, b);
      pulse(3);
      wt(1);
      chk({8'h00, STB}, 16'h0000);
      ctl.rd(SRQ_SEL_SRE, d);
      chk(d, 16'h00BC);
      @(posedge MCLK);
      #1 ESR_EVENTS = 8'h80;
      @(posedge MCLK);
      #1 ESR_EVENTS = 8'h00;
      chk({8'h00, STB}, 16'h0060);
      ctl.rd(SRQ_SEL_ESR, d);
      chk(d, 16'h0080);
   endtask
   task automatic t_meas();
      ctl.wr(SRQ_SEL_OENA, 16'h0010);
      ctl.wr(SRQ_SEL_ONTR, 16'h0010);
      ctl.wr(SRQ_SEL_OPTR, 16'h0000);
      MEASURING = 1'b1;
      wt(8);
      ctl.rd(SRQ_SEL_OCOND, d);
      chk(d & 16'h0010, 16'h0010);
      chk({8'h00, STB}, 16'h0000);
      MEASURING = 1'b0;
      wt(6);
      chk({8'h00, STB}, 16'h00C0);
      pulse(4);
      ctl.rd(SRQ_SEL_OENA, d);
      chk(d, 16'h0000);
      ctl.rd(SRQ_SEL_OPTR, d);
      chk(d, PTR_RESET);
      ctl.rd(SRQ_SEL_ONTR, d);
      chk(d, 16'h0000);
   endtask
   task automatic t_err();
      pulse(3);
      ctl.rd(SRQ_SEL_ERR, d);
      chk(d, ERR_NONE);
      for (int i = 1; i <= 31; i++)
      begin
         ERR_CODE = 16'(i);
         pulse(1);
      end
      chk({15'h0, STB[2]}, 16'h0001);
      for (int i = 1; i <= 31; i++)
      begin
         ctl.rd(SRQ_SEL_ERR, d);
         chk(d, i < 30 ? 16'(i) : i == 30 ? ERR_OVERFLOW : ERR_NONE);
      end
      MAV = 1'b1;
      pulse(2);
      ctl.rd(SRQ_SEL_ERR, d);
      chk(d, ERR_QUERY_INT);
      MAV = 1'b0;
   endtask
   task automatic t_pon();
      pulse(1);
      pulse(5);
      ctl.rd(SRQ_SEL_ERR, d);
      chk(d, ERR_NONE);
      @(posedge MCLK);
      #1 pl[6] = 1'b1;
      #1 chk({14'h0, CLEAR_OUTQ, PARSER_STOP}, 16'h0003);
      @(posedge MCLK);
      #1 pl[6] = 1'b0;
      #1 chk({14'h0, CLEAR_OUTQ, PARSER_STOP}, 16'h0000);
      ctl.rd(SRQ_SEL_SRE, d);
      chk(d, 16'h00BC);
      PON_CLEAR = 1'b1;
      pulse(5);
      ctl.rd(SRQ_SEL_PPE, d);
      chk(d, 16'h0000);
   endtask
   initial
   begin
      MCLK = 1'b0;
      forever #12.5 MCLK = ~MCLK;
   end
   always @(posedge MCLK)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   initial
   begin
      {RESETN, PON_CLEAR, MEASURING, MAV, ZERO_FAIL, ERR_CODE, pl} = '0;
      ESR_EVENTS = 8'h00;
      repeat (3) @(posedge MCLK);
      #1 RESETN = 1'b1;
      t_cal();
      t_srq();
      t_meas();
      t_err();
      t_pon();
      print_verdict();
   end
endmodule // status_reporting_srq_tb_top
`default_nettype wire
